// ---- logic/fcv_regs.vh ----
`ifndef FCV_REGS_VH
`define FCV_REGS_VH

// ==========================================
// register byte offsets
`define FCV_A_CTRL 8'h00
`define FCV_A_STAT 8'h04
`define FCV_A_MASK 8'h08
`define FCV_A_FSHI 8'h0C
`define FCV_A_FSLO 8'h10
`define FCV_A_FT 8'h14
`define FCV_A_INSTR 8'h18
`define FCV_A_RESHI 8'h1C
`define FCV_A_RESLO 8'h20
`define FCV_A_CAUSE 8'h24

// ==========================================
// control register fields and reset value
`define FCV_C_RM 1:0
`define FCV_C_USABLE 2
`define FCV_C_INVEN 3
`define FCV_C_DENTRAP 4
`define FCV_C_W 5
`define FCV_CTRL_RST 5'h00

// ==========================================
// status, mask and cause bit positions
`define FCV_S_DONE 0
`define FCV_S_TRAP 1
`define FCV_S_UNUS 2
`define FCV_S_RESV 3
`define FCV_S_INV 4
`define FCV_S_UNIMP 5
`define FCV_S_INEX 6
`define FCV_S_OVF 7
`define FCV_S_UFL 8
`define FCV_S_W 9
`define FCV_STAT_RST 9'h000

// ==========================================
// instruction word fields and codes
`define FCV_I_OPC 31:26
`define FCV_I_FMT 25:21
`define FCV_I_FT 20:16
`define FCV_I_FN 5:0
`define FCV_OP_UNIT 6'h11
`define FCV_FMT_S 5'h10
`define FCV_FMT_D 5'h11
`define FCV_FMT_W 5'h14
`define FCV_FMT_L 5'h15
`define FCV_FMT_PS 5'h16
`define FCV_FN_TOS 6'h20
`define FCV_FN_TOW 6'h24
`define FCV_FN_TOL 6'h25
`define FCV_FN_PACK 6'h26
`define FCV_FN_PL 6'h28

// ==========================================
// rounding modes and fixed results
`define FCV_RM_RN 2'h0
`define FCV_RM_RZ 2'h1
`define FCV_RM_RP 2'h2
`define FCV_RM_RM 2'h3
`define FCV_WORD_DEF 32'h7FFFFFFF
`define FCV_LONG_DEF 64'h7FFFFFFFFFFFFFFF
`define FCV_QNAN 32'h7FBFFFFF
`define FCV_SMAX 31'h7F7FFFFF

`endif

// ---- logic/fcv_unit.v ----
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fcv_regs.vh"

module fcv_unit (
    input wire hclk, // bus clock
    input wire hresetn, // asynchronous reset, active low
    input wire hsel, // slave select
    input wire [31:0] haddr, // byte address
    input wire [1:0] htrans, // transfer type
    input wire hwrite, // write when high
    input wire [2:0] hsize, // transfer size, word only
    input wire [31:0] hwdata, // write data
    input wire hready, // bus ready in
    output reg [31:0] hrdata, // read data
    output wire hreadyout, // always ready
    output wire hresp, // always okay
    output wire irq, // level interrupt
    output reg trap_pulse // one-cycle exception pulse
);

    // ==========================================
    // shared helpers
    // round-up decision for all conversions
    function fcv_rnd_inc;
        input [1:0] rm;
        input sgn;
        input lsb;
        input rb;
        input sb;
        begin
            case (rm)
                `FCV_RM_RN: fcv_rnd_inc = rb & (sb | lsb);
                `FCV_RM_RZ: fcv_rnd_inc = 1'b0;
                `FCV_RM_RP: fcv_rnd_inc = ~sgn & (rb | sb);
                default: fcv_rnd_inc = sgn & (rb | sb);
            endcase
        end
    endfunction

    // leading zero count of a 64-bit magnitude
    function [6:0] fcv_lzc64;
        input [63:0] v;
        integer i;
        reg found;
        begin
            fcv_lzc64 = 7'd64;
            found = 1'b0;
            for (i = 63; i >= 0; i = i - 1) begin
                if (!found && v[i]) begin
                    fcv_lzc64 = 7'd63 - i[6:0];
                    found = 1'b1;
                end
            end
        end
    endfunction

    // ==========================================
    // registers
    reg [4:0] ctrl_ff;
    reg [8:0] stat_ff;
    reg [8:0] mask_ff;
    reg [8:0] cause_ff;
    reg [31:0] fshi_ff;
    reg [31:0] fslo_ff;
    reg [31:0] ft_ff;
    reg [31:0] instr_ff;
    reg [63:0] res_ff;
    reg act_ff;
    reg wr_ff;
    reg [7:0] addr_ff;
    reg [31:0] nxt_rdata;

    wire issue = act_ff & wr_ff & (addr_ff == `FCV_A_INSTR);
    wire [63:0] src = {fshi_ff, fslo_ff};
    wire [1:0] rm = ctrl_ff[`FCV_C_RM];
    wire [4:0] fmt = hwdata[`FCV_I_FMT];
    wire [5:0] fn = hwdata[`FCV_I_FN];
    wire base_ok = (hwdata[`FCV_I_OPC] == `FCV_OP_UNIT);
    wire ft0 = (hwdata[`FCV_I_FT] == 5'h00);

    // ==========================================
    // decode; single-operand forms need a zero second field
    wire d_s = base_ok & ft0 & (fn == `FCV_FN_TOS) & (fmt == `FCV_FMT_D | fmt == `FCV_FMT_W | fmt == `FCV_FMT_L);
    wire d_pu = base_ok & ft0 & (fn == `FCV_FN_TOS) & (fmt == `FCV_FMT_PS);
    wire d_pl = base_ok & ft0 & (fn == `FCV_FN_PL) & (fmt == `FCV_FMT_PS);
    wire fs_sd = (fmt == `FCV_FMT_S) | (fmt == `FCV_FMT_D);
    wire d_w = base_ok & ft0 & (fn == `FCV_FN_TOW) & fs_sd;
    wire d_l = base_ok & ft0 & (fn == `FCV_FN_TOL) & fs_sd;
    wire d_ps = base_ok & (fn == `FCV_FN_PACK) & (fmt == `FCV_FMT_S);
    wire legal = d_s | d_pu | d_pl | d_w | d_l | d_ps;
    wire is_int = d_s & (fmt == `FCV_FMT_W | fmt == `FCV_FMT_L);
    wire is_dbl = (fmt == `FCV_FMT_D);
    wire [31:0] sp = d_pu ? src[63:32] : src[31:0];

    // ==========================================
    // unpack, normalise and convert
    reg sgn, all1, e0, fr_nz, qb;
    reg [63:0] man, nman, ival, mag_t, m2;
    reg signed [12:0] ue, ne, eb, dsh13;
    reg [6:0] lz, sh;
    reg [5:0] dsh;
    reg [127:0] t;
    reg [64:0] mag, lim;
    reg rb, sb, big, edge_min, ovf_i, inv_i, r2, s2, lost, nrm, ovf2, uselmax;
    reg [24:0] sum;
    reg [11:0] base;
    reg [34:0] tmp;
    reg [31:0] sres;
    reg f_inv, f_unimp, f_inex, f_ovf, f_ufl, nan, inf, zero, den;
    reg [63:0] result;

    always @* begin
        // source unpack into magnitude and unbiased exponent
        ival = (fmt == `FCV_FMT_L) ? src : {{32{src[31]}}, src[31:0]};
        if (is_int) begin
            sgn = ival[63];
            man = sgn ? (~ival + 64'h1) : ival;
            ue = 13'sd63;
            all1 = 1'b0;
            e0 = 1'b0;
            fr_nz = 1'b0;
            qb = 1'b0;
        end else if (is_dbl) begin
            sgn = src[63];
            all1 = &src[62:52];
            e0 = ~|src[62:52];
            fr_nz = |src[51:0];
            qb = src[51];
            man = {~e0, src[51:0], 11'h000};
            ue = (e0 ? 13'sd1 : {2'b00, src[62:52]}) - 13'sd1023;
        end else begin
            sgn = sp[31];
            all1 = &sp[30:23];
            e0 = ~|sp[30:23];
            fr_nz = |sp[22:0];
            qb = sp[22];
            man = {~e0, sp[22:0], 40'h0};
            ue = (e0 ? 13'sd1 : {5'b00000, sp[30:23]}) - 13'sd127;
        end
        nan = all1 & fr_nz;
        inf = all1 & ~fr_nz;
        den = ~is_int & e0 & fr_nz;
        zero = (man == 64'h0) & ~all1;
        lz = fcv_lzc64(man);
        nman = man << lz;
        ne = ue - {6'b000000, lz};
        // to integer: shift so the binary point sits at bit 64
        big = (ne > 13'sd62);
        edge_min = (ne == 13'sd63) & (nman[62:0] == 63'h0) & sgn & d_l;
        sh = (ne < -13'sd64) ? 7'd127 : (7'd63 - ne[6:0]);
        t = {nman, 64'h0} >> sh;
        rb = t[63];
        sb = |t[62:0];
        mag = {1'b0, t[127:64]} + {64'h0, fcv_rnd_inc(rm, sgn, t[64], rb, sb)};
        if (edge_min)
            mag = {2'b01, 63'h0};
        lim = d_l ? (sgn ? {2'b01, 63'h0} : {2'b00, {63{1'b1}}}) : (sgn ? 65'h080000000 : 65'h07FFFFFFF);
        ovf_i = (big & ~edge_min) | (mag > lim);
        inv_i = nan | inf | ovf_i;
        mag_t = sgn ? (~mag[63:0] + 64'h1) : mag[63:0];
        // to single: denormal shift, round to 24 bits, rebias
        eb = ne + 13'sd127;
        nrm = (eb > 13'sd0);
        dsh13 = 13'sd1 - eb;
        dsh = nrm ? 6'd0 : ((dsh13 > 13'sd63) ? 6'd63 : dsh13[5:0]);
        m2 = nman >> dsh;
        lost = ((m2 << dsh) != nman);
        r2 = m2[39];
        s2 = (|m2[38:0]) | lost;
        sum = {1'b0, m2[63:40]} + {24'h0, fcv_rnd_inc(rm, sgn, m2[40], r2, s2)};
        base = nrm ? (eb[11:0] - 12'd1) : 12'd0;
        tmp = {base, 23'h0} + {10'h0, sum};
        ovf2 = (tmp[34:23] >= 12'd255);
        uselmax = (rm == `FCV_RM_RZ) | ((rm == `FCV_RM_RP) & sgn) | ((rm == `FCV_RM_RM) & ~sgn);
        if (nan)
            sres = `FCV_QNAN;
        else if (inf)
            sres = {sgn, 8'hFF, 23'h0};
        else if (zero)
            sres = {sgn, 31'h0};
        else if (ovf2)
            sres = uselmax ? {sgn, `FCV_SMAX} : {sgn, 8'hFF, 23'h0};
        else
            sres = {sgn, tmp[30:0]};
        // flags and result per operation
        f_inv = 1'b0;
        f_unimp = 1'b0;
        f_inex = 1'b0;
        f_ovf = 1'b0;
        f_ufl = 1'b0;
        result = 64'h0;
        if (d_ps) begin
            result = {src[31:0], ft_ff};
        end else if (d_w | d_l) begin
            f_inv = inv_i;
            f_inex = ~inv_i & (rb | sb);
            f_unimp = den & ctrl_ff[`FCV_C_DENTRAP];
            if (d_w)
                result = inv_i ? {32'h0, `FCV_WORD_DEF} : {32'h0, mag_t[31:0]};
            else
                result = inv_i ? `FCV_LONG_DEF : mag_t;
        end else begin
            f_inv = nan & ~qb;
            f_unimp = den & ctrl_ff[`FCV_C_DENTRAP];
            f_inex = ~nan & ~inf & ~zero & (r2 | s2 | ovf2);
            f_ovf = ~nan & ~inf & ~zero & ovf2;
            f_ufl = ~zero & ~nan & ~inf & ~nrm & (r2 | s2);
            result = {32'h0, sres};
        end
    end

    // ==========================================
    // issue outcome
    wire unus = ~ctrl_ff[`FCV_C_USABLE];
    wire resv = ~unus & ~legal;
    wire run = ~unus & legal;
    wire fp_trap = run & (f_unimp | (f_inv & ctrl_ff[`FCV_C_INVEN]));
    wire wr_res = run & ~fp_trap;
    wire [8:0] ev = {f_ufl & run, f_ovf & run, f_inex & run, f_unimp & run, f_inv & run, resv, unus, fp_trap, wr_res};

    // ==========================================
    // bus slave: address phase capture and read mux
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(stat_ff & mask_ff);

    always @* begin
        if (haddr[7:0] == `FCV_A_CTRL)
            nxt_rdata = {27'h0, ctrl_ff};
        else if (haddr[7:0] == `FCV_A_STAT)
            nxt_rdata = {23'h0, stat_ff};
        else if (haddr[7:0] == `FCV_A_MASK)
            nxt_rdata = {23'h0, mask_ff};
        else if (haddr[7:0] == `FCV_A_FSHI)
            nxt_rdata = fshi_ff;
        else if (haddr[7:0] == `FCV_A_FSLO)
            nxt_rdata = fslo_ff;
        else if (haddr[7:0] == `FCV_A_FT)
            nxt_rdata = ft_ff;
        else if (haddr[7:0] == `FCV_A_INSTR)
            nxt_rdata = instr_ff;
        else if (haddr[7:0] == `FCV_A_RESHI)
            nxt_rdata = res_ff[63:32];
        else if (haddr[7:0] == `FCV_A_RESLO)
            nxt_rdata = res_ff[31:0];
        else if (haddr[7:0] == `FCV_A_CAUSE)
            nxt_rdata = {23'h0, cause_ff};
        else
            nxt_rdata = 32'h0;
    end

    // ==========================================
    // register writes, issue and sticky status
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_ff <= 1'b0;
            wr_ff <= 1'b0;
            addr_ff <= 8'h00;
            hrdata <= 32'h0;
            ctrl_ff <= `FCV_CTRL_RST;
            stat_ff <= `FCV_STAT_RST;
            mask_ff <= `FCV_STAT_RST;
            cause_ff <= `FCV_STAT_RST;
            fshi_ff <= 32'h0;
            fslo_ff <= 32'h0;
            ft_ff <= 32'h0;
            instr_ff <= 32'h0;
            res_ff <= 64'h0;
            trap_pulse <= 1'b0;
        end else begin
            act_ff <= hsel & htrans[1] & hready;
            wr_ff <= hwrite;
            addr_ff <= haddr[7:0];
            if (hsel & htrans[1] & hready & ~hwrite)
                hrdata <= nxt_rdata;
            if (act_ff & wr_ff) begin
                if (addr_ff == `FCV_A_CTRL)
                    ctrl_ff <= hwdata[`FCV_C_W-1:0];
                else if (addr_ff == `FCV_A_MASK)
                    mask_ff <= hwdata[`FCV_S_W-1:0];
                else if (addr_ff == `FCV_A_FSHI)
                    fshi_ff <= hwdata;
                else if (addr_ff == `FCV_A_FSLO)
                    fslo_ff <= hwdata;
                else if (addr_ff == `FCV_A_FT)
                    ft_ff <= hwdata;
                else if (addr_ff == `FCV_A_INSTR)
                    instr_ff <= hwdata;
            end
            // new events win over a write-one clear in the same cycle
            stat_ff <= (stat_ff & ~((act_ff & wr_ff & (addr_ff == `FCV_A_STAT)) ? hwdata[8:0] : 9'h000))
                | (issue ? ev : 9'h000);
            if (issue)
                cause_ff <= ev;
            if (issue & wr_res)
                res_ff <= result;
            trap_pulse <= issue & (fp_trap | unus | resv);
        end
    end

endmodule // fcv_unit

`default_nettype wire

// ---- verif/fcv_issuer.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// issuing side: single word transfers only
module fcv_issuer (
    input wire logic hclk, // bus clock
    input wire logic hready, // bus ready
    output logic hsel, // slave select
    output logic [31:0] haddr, // byte address
    output logic [1:0] htrans, // transfer type
    output logic hwrite, // write strobe
    output logic [2:0] hsize, // word size
    output logic [31:0] hwdata, // write data
    output logic stuck // a wait ran out
);
    // idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        stuck = 1'b0;
    end
    // wait for an edge with ready high, bounded
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (!hready && n < 64);
        if (!hready) stuck <= 1'b1;
    endtask
    // address phase, then data phase; released data shows its inverse
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        hwdata <= ~d;
    endtask
endmodule // fcv_issuer
`default_nettype wire

// ---- verif/fcv_unit_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checks of the conversion unit
module fcv_unit_assertions (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write strobe
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic irq, // interrupt
    input wire logic trap_pulse // exception pulse
);
    // address phases taken by the slave
    wire logic acc = hsel && htrans[1] && hready;
    wire logic rd = acc && !hwrite;
    wire logic wr = acc && hwrite;
    wire logic iss = wr && (haddr[7:0] == 8'h18);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // bus answers and read data
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    AST_RD_HOLD: assert property ($changed(hrdata) |-> $past(rd))
        else $error("read data moved without a read");
    AST_UNMAPPED_ZERO: assert property ($past(rd && haddr[7:0] > 8'h24) |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_CTRL_WIDTH: assert property ($past(rd && haddr[7:0] == 8'h00) |-> hrdata[31:5] == 27'h0)
        else $error("control upper bits not zero");
    AST_FLAG_WIDTH: assert property ($past(rd && haddr[7:0] inside {8'h04, 8'h08, 8'h24})
        |-> hrdata[31:9] == 23'h0)
        else $error("flag register upper bits not zero");
    // exception pulse and interrupt timing
    AST_TRAP_CAUSE: assert property (trap_pulse |-> $past(iss, 2))
        else $error("trap without an issue");
    AST_TRAP_SINGLE: assert property (trap_pulse && !$past(iss) |=> !trap_pulse)
        else $error("trap pulse longer than one cycle");
    AST_IRQ_CAUSE: assert property ($changed(irq) |-> $past(wr, 2))
        else $error("interrupt moved without a write");
    AST_RESET_QUIET: assert property ($rose(hresetn) |-> !irq && !trap_pulse)
        else $error("outputs active after reset");
    COV_TRAP: cover property (trap_pulse);
    COV_IRQ: cover property ($rose(irq));
    COV_UNMAPPED: cover property (rd && haddr[7:0] == 8'h40);
endmodule // fcv_unit_assertions

bind fcv_unit fcv_unit_assertions chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .trap_pulse(trap_pulse));
`default_nettype wire

// ---- verif/test_fcv_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fcv_regs.vh"
// ==========================================
// bench top
module test_fcv_unit;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    wire hsel, hwrite, hready, hresp, irq, trap_pulse, stuck;
    wire [31:0] haddr, hwdata, hrdata;
    wire [1:0] htrans;
    wire [2:0] hsize;
    int error_cnt = 0;
    int comparisons = 0;
    logic [31:0] exp_q[$];
    string nam_q[$];
    logic rd_pend = 1'b0;
    logic [1:0] iss_d = 2'b00;
    logic trp_q[$];
    logic [63:0] last = 64'h0;
    logic [31:0] a, ft_v = 32'h0;
    logic [4:0] f2_v = 5'h0;
    logic [31:0] pos_t[4] = '{32'h2, 32'h2, 32'h3, 32'h2};
    logic [31:0] neg_t[4] = '{32'hFFFFFFFE, 32'hFFFFFFFE, 32'hFFFFFFFE, 32'hFFFFFFFD};

    always #2.5 hclk = ~hclk;

    fcv_unit dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .irq(irq), .trap_pulse(trap_pulse));
    fcv_issuer bus_u (.hclk(hclk), .hready(hready), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .stuck(stuck));

    // compare and report
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // bus tasks; a read notes its expected value first
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bus_u.xfer(1'b1, ad, d);
    endtask
    task automatic rd(input logic [7:0] ad, input string n, input logic [31:0] e);
        exp_q.push_back(e);
        nam_q.push_back(n);
        bus_u.xfer(1'b0, ad, 32'h0);
    endtask
    task automatic irq_is(input logic e);
        #1;
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    // load sources, issue one conversion, read result and cause
    task automatic run(input logic [4:0] fm, input logic [5:0] fn, input logic [4:0] ct,
        input logic [63:0] s, input logic [63:0] r, input logic [8:0] c);
        wr(`FCV_A_CTRL, {27'h0, ct});
        wr(`FCV_A_FSHI, s[63:32]);
        wr(`FCV_A_FSLO, s[31:0]);
        wr(`FCV_A_FT, ft_v);
        trp_q.push_back(|c[3:1]);
        wr(`FCV_A_INSTR, {`FCV_OP_UNIT, fm, f2_v, 10'h0, fn});
        rd(`FCV_A_RESHI, "res_hi", r[63:32]);
        rd(`FCV_A_RESLO, "res_lo", r[31:0]);
        rd(`FCV_A_CAUSE, "cause", {23'h0, c});
        last = r;
        $display("test fmt %h fn %h done", fm, fn);
    endtask

    // read data checked at the end of each read data phase
    always @(posedge hclk) begin
        if (rd_pend) chk(nam_q.pop_front(), exp_q.pop_front(), hrdata);
        rd_pend <= hsel && htrans[1] && hready && !hwrite;
    end
    // exception pulse checked one edge after the issuing data phase
    always @(posedge hclk) begin
        if (iss_d[1]) chk("trap_pulse", {31'h0, trp_q.pop_front()}, {31'h0, trap_pulse});
        iss_d <= {iss_d[0], hsel && htrans[1] && hready && hwrite && haddr[7:0] == `FCV_A_INSTR};
    end
    // a bus wait that ran out ends the run
    always @(posedge stuck) begin
        error_cnt++;
        complete_run;
    end

    // main sequence
    initial begin
        void'($urandom(32'h0D4C));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`FCV_A_CTRL, "ctrl", 32'h0);
        rd(`FCV_A_STAT, "status", 32'h0);
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, "unmapped", 32'h0);
        for (int i = 0; i < 4; i++) begin
            a = $urandom;
            run(`FCV_FMT_S, `FCV_FN_TOW, {3'h1, i[1:0]}, {a, 32'h40200000}, {32'h0, pos_t[i]}, 9'h041);
            run(`FCV_FMT_S, `FCV_FN_TOW, {3'h1, i[1:0]}, {a, 32'hC0200000}, {32'h0, neg_t[i]}, 9'h041);
        end
        wr(`FCV_A_MASK, 32'h10);
        run(`FCV_FMT_S, `FCV_FN_TOW, 5'h04, {a, 32'h7F800000}, 64'h7FFFFFFF, 9'h011);
        irq_is(1'b1);
        wr(`FCV_A_MASK, 32'h0);
        irq_is(1'b0);
        wr(`FCV_A_MASK, 32'h10);
        irq_is(1'b1);
        wr(`FCV_A_STAT, 32'h1FF);
        irq_is(1'b0);
        run(`FCV_FMT_S, `FCV_FN_TOW, 5'h04, {a, 32'hCF000000}, 64'h80000000, 9'h001);
        run(`FCV_FMT_S, `FCV_FN_TOW, 5'h0C, {a, 32'h4F000000}, last, 9'h012);
        run(`FCV_FMT_D, `FCV_FN_TOL, 5'h04, 64'h3FF0000000000000, 64'h1, 9'h001);
        run(`FCV_FMT_D, `FCV_FN_TOL, 5'h04, 64'h7FF8000000000000, `FCV_LONG_DEF, 9'h011);
        run(`FCV_FMT_D, `FCV_FN_TOS, 5'h04, 64'h3FF0000000000000, 64'h3F800000, 9'h001);
        run(`FCV_FMT_W, `FCV_FN_TOS, 5'h04, {a, 32'h3}, 64'h40400000, 9'h001);
        run(`FCV_FMT_L, `FCV_FN_TOS, 5'h04, 64'h5, 64'h40A00000, 9'h001);
        run(`FCV_FMT_D, `FCV_FN_TOS, 5'h04, 64'h7FEFFFFFFFFFFFFF, 64'h7F800000, 9'h0C1);
        run(`FCV_FMT_D, `FCV_FN_TOS, 5'h04, 64'h3690000000000000, 64'h0, 9'h141);
        run(`FCV_FMT_PS, `FCV_FN_TOS, 5'h04, 64'h3F80000040000000, 64'h3F800000, 9'h001);
        run(`FCV_FMT_PS, `FCV_FN_PL, 5'h04, 64'h3F80000040000000, 64'h40000000, 9'h001);
        run(`FCV_FMT_D, `FCV_FN_TOW, 5'h04, 64'hC00C000000000000, 64'hFFFFFFFC, 9'h041);
        run(`FCV_FMT_S, `FCV_FN_TOL, 5'h04, {a, 32'hBF800000}, 64'hFFFFFFFFFFFFFFFF, 9'h001);
        run(`FCV_FMT_D, `FCV_FN_TOS, 5'h04, 64'h7FF0000000000001, {32'h0, `FCV_QNAN}, 9'h011);
        run(`FCV_FMT_S, `FCV_FN_TOW, 5'h14, {a, 32'h00000001}, last, 9'h062);
        repeat (3) begin
            a = $urandom;
            ft_v = $urandom;
            run(`FCV_FMT_S, `FCV_FN_PACK, 5'h04, {$urandom, a}, {a, ft_v}, 9'h001);
        end
        ft_v = 32'h0;
        run(`FCV_FMT_S, `FCV_FN_TOW, 5'h00, {a, 32'h40200000}, last, 9'h004);
        f2_v = 5'h1;
        run(`FCV_FMT_S, `FCV_FN_TOW, 5'h04, {a, 32'h40200000}, last, 9'h008);
        f2_v = 5'h0;
        run(`FCV_FMT_W, `FCV_FN_TOW, 5'h04, {a, 32'h40200000}, last, 9'h008);
        // reset in mid-run brings the unit back to unusable with clear registers
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`FCV_A_CTRL, "ctrl", 32'h0);
        rd(`FCV_A_RESLO, "res_lo", 32'h0);
        rd(`FCV_A_STAT, "status", 32'h0);
        $display("test mid-run reset done");
        complete_run;
    end
endmodule // test_fcv_unit
`default_nettype wire
